// *** logic/supervisor_defines.vh ***
// Constants for the system reset supervisor and supervision timer
// Overview of operation
// - Hold reset until power-good, then delay release
// - Seventeen reset delays: zero, then 1 ms doubling
// - Level mode: release on good, reassert after delay
// - Pulse mode: one programmable-width pulse after delay
// - Expiry toggles reset, fixed or input-tracking release
// - Kick pin toggle or bus command clears count
// - Kick pin and expiry pin each optional
// - Initial wait: zero, then 100 ms doubling
// - Timeout programmable 1 ms to about 32 s
// - Expiry drives expiry pin or reset pulse
// - After expiry, stopped until kicked again
// - Timer runs independently or drives system reset
// - General input polarity selectable high or low
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH
`define CLK_FREQ_HZ      20000000
`define TICK_PERIOD_US   1000
`define TICK_CYCLES      ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)
`define DELAY_SEL_W      5
`define DELAY_SEL_MAX    5'h10
`define WAIT_SEL_W       4
`define WAIT_BASE_MS     100
`define MS_CNT_W         22
`define PULSE_MS_MAX     16'd32256
`define PULSE_MS_MIN     16'd1
`define TIMEOUT_MS_MAX   16'd32256
`define TIMEOUT_MS_MIN   16'd1
`endif

// *** logic/ms_tick_gen.v ***
// One-millisecond tick generator
`timescale 1ns/10ps
`include "supervisor_defines.vh"
module ms_tick_gen #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire i_clk_sys,
  input  wire i_rst_n,
  output reg  o_tick
);
  reg [31:0] count;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      count  <= 32'h0;
      o_tick <= 1'b0;
    end else if (count == TICK_CYCLES - 1) begin
      count  <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      count  <= count + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule

// *** logic/watchdog_system_reset_supervisor.v ***
// System reset generator and supervision timer
`timescale 1ns/10ps
`include "supervisor_defines.vh"
module watchdog_system_reset_supervisor #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_power_good,
  input  wire        i_pulse_mode,
  input  wire [4:0]  i_delay_sel,
  input  wire [15:0] i_pulse_ms,
  input  wire        i_timer_enable,
  input  wire        i_kick_pin_enable,
  input  wire        i_kick_input_pin,
  input  wire        i_kick_cmd,
  input  wire [3:0]  i_wait_sel,
  input  wire [15:0] i_timeout_ms,
  input  wire        i_expiry_to_reset,
  input  wire        i_track_release,
  input  wire        i_track_input_pin,
  input  wire        i_track_active_high,
  output reg         o_system_reset_n,
  output reg         o_expiry_output_pin,
  output reg         o_timer_running,
  output reg         o_timer_expired
);
  localparam RS_HOLD    = 5'h01;
  localparam RS_DELAY   = 5'h02;
  localparam RS_RUN     = 5'h04;
  localparam RS_PULSE   = 5'h08;
  localparam RS_OFFDLY  = 5'h10;
  localparam WD_IDLE    = 4'h1;
  localparam WD_WAIT    = 4'h2;
  localparam WD_COUNT   = 4'h4;
  localparam WD_EXPIRED = 4'h8;

  wire tick;
  ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .o_tick    (tick)
  );

  // Pins are asynchronous; two flops before any logic reads them
  reg  [1:0] pg_sync;
  reg  [1:0] kick_sync;
  reg  [1:0] trk_sync;
  reg        kick_last;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pg_sync   <= 2'h0;
      kick_sync <= 2'h0;
      trk_sync  <= 2'h0;
      kick_last <= 1'b0;
    end else begin
      pg_sync   <= {pg_sync[0], i_power_good};
      kick_sync <= {kick_sync[0], i_kick_input_pin};
      trk_sync  <= {trk_sync[0], i_track_input_pin};
      kick_last <= kick_sync[1];
    end
  end
  wire power_good = pg_sync[1];
  // Either edge counts as a kick; a disabled pin falls back to the command
  wire kick = (i_kick_pin_enable & (kick_sync[1] ^ kick_last)) | i_kick_cmd;
  wire track_asserted = trk_sync[1] ~^ i_track_active_high;

  // Delay setting 0 is zero, setting n is 2^(n-1) ms; top setting 32768 ms
  wire [4:0] dsel = (i_delay_sel > `DELAY_SEL_MAX) ? `DELAY_SEL_MAX : i_delay_sel;
  wire [21:0] delay_ms = (dsel == 5'h0) ? 22'h0 : (22'h1 << (dsel - 5'h1));
  wire [21:0] wait_ms = (i_wait_sel == 4'h0) ? 22'h0 :
                        (22'd100 << (i_wait_sel - 4'h1));
  wire [15:0] pulse_ms = (i_pulse_ms < `PULSE_MS_MIN) ? `PULSE_MS_MIN :
                         (i_pulse_ms > `PULSE_MS_MAX) ? `PULSE_MS_MAX : i_pulse_ms;
  wire [15:0] tmo_ms = (i_timeout_ms < `TIMEOUT_MS_MIN) ? `TIMEOUT_MS_MIN :
                       (i_timeout_ms > `TIMEOUT_MS_MAX) ? `TIMEOUT_MS_MAX : i_timeout_ms;

  reg [3:0]  wd_state;
  reg [21:0] wd_ms;
  wire expiry_event = (wd_state == WD_COUNT) & tick & (wd_ms + 22'h1 >= {6'h0, tmo_ms}) & ~kick;

  reg [4:0]  rs_state;
  reg [21:0] rs_ms;
  reg        wd_reset_req;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rs_state         <= RS_HOLD;
      rs_ms            <= 22'h0;
      o_system_reset_n <= 1'b0;
      wd_reset_req     <= 1'b0;
    end else begin
      case (rs_state)
        RS_HOLD: begin
          o_system_reset_n <= 1'b0;
          rs_ms            <= 22'h0;
          if (power_good & !(i_track_release & wd_reset_req & !track_asserted)) begin
            rs_state     <= RS_DELAY;
            wd_reset_req <= 1'b0;
          end
        end
        RS_DELAY: begin
          if (!power_good) begin
            rs_state <= RS_HOLD;
          end else if (rs_ms >= delay_ms) begin
            rs_ms <= 22'h0;
            if (i_pulse_mode) begin
              o_system_reset_n <= 1'b0;
              rs_state         <= RS_PULSE;
            end else begin
              o_system_reset_n <= 1'b1;
              rs_state         <= RS_RUN;
            end
          end else if (tick) begin
            rs_ms <= rs_ms + 22'h1;
          end
        end
        RS_PULSE: begin
          // Losing the rails mid-pulse must not end the pulse with a release
          if (!power_good) begin
            rs_state <= RS_HOLD;
          end else if (tick) begin
            if (rs_ms + 22'h1 >= {6'h0, pulse_ms}) begin
              o_system_reset_n <= 1'b1;
              rs_state         <= RS_RUN;
              rs_ms            <= 22'h0;
            end else begin
              rs_ms <= rs_ms + 22'h1;
            end
          end
        end
        RS_RUN: begin
          o_system_reset_n <= 1'b1;
          if (wd_reset_req | (expiry_event & i_expiry_to_reset)) begin
            o_system_reset_n <= 1'b0;
            rs_state         <= RS_HOLD;
          end else if (!power_good) begin
            rs_state <= i_pulse_mode ? RS_HOLD : RS_OFFDLY;
          end
        end
        RS_OFFDLY: begin
          // Level mode reasserts only after the common delay
          if (power_good) begin
            rs_state <= RS_RUN;
            rs_ms    <= 22'h0;
          end else if (rs_ms >= delay_ms) begin
            o_system_reset_n <= 1'b0;
            rs_state         <= RS_HOLD;
          end else if (tick) begin
            rs_ms <= rs_ms + 22'h1;
          end
        end
        default: begin
          rs_state         <= RS_HOLD;
          o_system_reset_n <= 1'b0;
        end
      endcase
      // Sticky until the reset sequence serves it; a set wins over the clear in hold
      if (expiry_event & i_expiry_to_reset)
        wd_reset_req <= 1'b1;
    end
  end

  // Tied mode starts the timer only once the reset is released
  wire wd_allowed = i_timer_enable & (!i_expiry_to_reset | o_system_reset_n);
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wd_state            <= WD_IDLE;
      wd_ms               <= 22'h0;
      o_expiry_output_pin <= 1'b0;
      o_timer_running     <= 1'b0;
      o_timer_expired     <= 1'b0;
    end else begin
      case (wd_state)
        WD_IDLE: begin
          o_timer_running <= 1'b0;
          wd_ms           <= 22'h0;
          if (wd_allowed) begin
            wd_state        <= WD_WAIT;
            o_timer_running <= 1'b1;
          end
        end
        WD_WAIT: begin
          if (!i_timer_enable) begin
            wd_state <= WD_IDLE;
          end else if (wd_ms >= wait_ms) begin
            wd_state <= WD_COUNT;
            wd_ms    <= 22'h0;
          end else if (tick) begin
            wd_ms <= wd_ms + 22'h1;
          end
        end
        WD_COUNT: begin
          if (!i_timer_enable) begin
            wd_state <= WD_IDLE;
          end else if (kick) begin
            wd_ms <= 22'h0;
          end else if (expiry_event) begin
            wd_state        <= WD_EXPIRED;
            o_timer_running <= 1'b0;
            o_timer_expired <= 1'b1;
            if (!i_expiry_to_reset)
              o_expiry_output_pin <= 1'b1;
          end else if (tick) begin
            wd_ms <= wd_ms + 22'h1;
          end
        end
        WD_EXPIRED: begin
          // Stays stopped; only a kick restarts timing, without the initial wait
          if (kick) begin
            wd_state            <= WD_COUNT;
            wd_ms               <= 22'h0;
            o_expiry_output_pin <= 1'b0;
            o_timer_expired     <= 1'b0;
            o_timer_running     <= 1'b1;
          end else if (!i_timer_enable) begin
            wd_state            <= WD_IDLE;
            o_expiry_output_pin <= 1'b0;
            o_timer_expired     <= 1'b0;
          end
        end
        default: begin
          wd_state <= WD_IDLE;
        end
      endcase
    end
  end
endmodule

// *** tb/supervisor_checker.sv ***
// Assertions on the reset supervisor and supervision timer ports
`timescale 1ns/10ps
module supervisor_checker #(
  parameter TICK_CYCLES = 20000
) (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire        i_power_good,
  input wire        i_pulse_mode,
  input wire        i_timer_enable,
  input wire        i_kick_pin_enable,
  input wire        i_kick_cmd,
  input wire [15:0] i_timeout_ms,
  input wire        i_expiry_to_reset,
  input wire        o_system_reset_n,
  input wire        o_expiry_output_pin,
  input wire        o_timer_running,
  input wire        o_timer_expired
);
  // Unbroken running cycles; kicks only lengthen it, so only a lower bound is safe
  integer run_cnt;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n || !o_timer_running) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end
  property p_reset_clears;
    @(posedge i_clk_sys) !i_rst_n |=> !o_system_reset_n && !o_expiry_output_pin && !o_timer_running;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("outputs active in reset");
  property p_release_needs_pg;
    @(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_system_reset_n) |-> $past(i_power_good, 3);
  endproperty
  a_release_needs_pg: assert property (p_release_needs_pg) else $error("release without good");
  property p_pg_loss_pulse;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(i_power_good) && i_pulse_mode |-> ##[1:6] !o_system_reset_n;
  endproperty
  a_pg_loss_pulse: assert property (p_pg_loss_pulse) else $error("reset not reasserted");
  property p_pin_on_expiry;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_expiry_output_pin) |-> o_timer_expired && !i_expiry_to_reset;
  endproperty
  a_pin_on_expiry: assert property (p_pin_on_expiry) else $error("expiry pin misfired");
  property p_expiry_to_reset;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_timer_expired) && i_expiry_to_reset |-> ##[0:2] !o_system_reset_n;
  endproperty
  a_expiry_to_reset: assert property (p_expiry_to_reset) else $error("no reset on expiry");
  property p_stopped;
    @(posedge i_clk_sys) disable iff (!i_rst_n) o_timer_expired |-> !o_timer_running;
  endproperty
  a_stopped: assert property (p_stopped) else $error("timer runs while expired");
  property p_stays;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_timer_expired && !i_kick_cmd && !i_kick_pin_enable && i_timer_enable |=> o_timer_expired;
  endproperty
  a_stays: assert property (p_stays) else $error("expiry cleared without kick");
  property p_cmd_restarts;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_timer_expired && i_kick_cmd && i_timer_enable && !i_expiry_to_reset |-> ##[1:3] o_timer_running;
  endproperty
  a_cmd_restarts: assert property (p_cmd_restarts) else $error("command did not restart");
  property p_min_timeout;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_timer_expired) |-> run_cnt + TICK_CYCLES >= i_timeout_ms * TICK_CYCLES;
  endproperty
  a_min_timeout: assert property (p_min_timeout) else $error("expiry too early");
endmodule
bind watchdog_system_reset_supervisor supervisor_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_power_good(i_power_good),
  .i_pulse_mode(i_pulse_mode), .i_timer_enable(i_timer_enable),
  .i_kick_pin_enable(i_kick_pin_enable), .i_kick_cmd(i_kick_cmd), .i_timeout_ms(i_timeout_ms),
  .i_expiry_to_reset(i_expiry_to_reset), .o_system_reset_n(o_system_reset_n),
  .o_expiry_output_pin(o_expiry_output_pin), .o_timer_running(o_timer_running),
  .o_timer_expired(o_timer_expired));

// *** tb/host_cpu_model.sv ***
// Watched processor that toggles the kick pin while it is alive
`timescale 1ns/10ps
module host_cpu_model (
  input  wire       i_clk_sys,
  input  wire       i_alive,
  input  wire [7:0] i_period,
  output reg        o_kick
);
  integer cnt;
  initial begin
    o_kick = 1'b0;
    cnt = 0;
  end
  // A hung processor just stops toggling; that is what the timer must catch
  always @(negedge i_clk_sys) begin
    cnt = i_alive ? cnt + 1 : 0;
    if (cnt >= i_period) begin
      o_kick <= ~o_kick;
      cnt = 0;
    end
  end
endmodule

// *** tb/watchdog_system_reset_supervisor_tb.sv ***
// Self-checking bench for the reset supervisor and supervision timer
`timescale 1ns/10ps
module watchdog_system_reset_supervisor_tb;
  localparam T = 20;
  reg        clk, rst_n, pg, pmode, ten, kpe, kcmd, e2r, alive, trel, tpin, tpol;
  reg [4:0]  dsel;
  reg [15:0] pms, tms;
  reg [3:0]  wsel;
  wire       kpin, rst_o, xpin, run, xp;
  integer    err_total, check_count, cyc, seed, i, d;
  host_cpu_model i_host (.i_clk_sys(clk), .i_alive(alive), .i_period(8'h0a), .o_kick(kpin));
  watchdog_system_reset_supervisor #(.TICK_CYCLES(T)) i_watchdog_system_reset_supervisor (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_power_good(pg), .i_pulse_mode(pmode),
    .i_delay_sel(dsel), .i_pulse_ms(pms), .i_timer_enable(ten), .i_kick_pin_enable(kpe),
    .i_kick_input_pin(kpin), .i_kick_cmd(kcmd), .i_wait_sel(wsel), .i_timeout_ms(tms),
    .i_expiry_to_reset(e2r), .i_track_release(trel), .i_track_input_pin(tpin),
    .i_track_active_high(tpol), .o_system_reset_n(rst_o), .o_expiry_output_pin(xpin),
    .o_timer_running(run), .o_timer_expired(xp));
  task chk(input [15:0] seen, input [15:0] exp, input [8*12-1:0] nm);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(negedge clk);
    end
  endtask
  task end_of_test;
    begin
      if (err_total == 0 && check_count > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  initial begin
    {pg, pmode, ten, kpe, kcmd, e2r, alive, trel, tpin, tpol, dsel, pms, tms, wsel} = 0;
    rst_n = 0; err_total = 0; check_count = 0; cyc = 0; seed = 32'h427b;
    wt(3);
    // Release and reassert for the short delay settings
    for (i = 0; i < 5; i = i + 1) begin
      dsel = i; d = (i == 0) ? 0 : (1 << (i - 1));
      rst_n = 1; pg = 1;
      wt((d - 1) * T);
      chk(rst_o, 0, "rst_early");
      wt(T + 10);
      chk(rst_o, 1, "rst_rel");
      pg = 0;
      wt((d - 1) * T);
      chk(rst_o, 1, "rst_keep");
      wt(T + 10);
      chk(rst_o, 0, "rst_drop");
      rst_n = 0; wt(3);
    end
    // Out-of-range settings clamp to the longest delay, not a short one
    dsel = 17 + ({$random(seed)} % 15); rst_n = 1; pg = 1;
    wt(100 * T);
    chk(rst_o, 0, "rst_clamp");
    rst_n = 0; pmode = 1; dsel = 2; pms = 3; wt(3); rst_n = 1;
    wt(5 * T + 10);
    chk(rst_o, 1, "pulse_end");
    pg = 0; wt(8);
    chk(rst_o, 0, "pulse_off");
    // Independent timer: initial wait, then timeout with no kicks
    rst_n = 0; pmode = 0; pg = 1; dsel = 0; ten = 1; kpe = 1; wsel = 1;
    tms = 2 + ({$random(seed)} % 3); wt(3); rst_n = 1;
    wt(100 * T);
    chk(xp, 0, "wait_hold");
    wt((tms + 1) * T + 10);
    chk(xp, 1, "expired");
    chk(xpin, 1, "expiry_pin");
    wt(5 * T);
    chk(xp, 1, "stay_stop");
    kcmd = 1; wt(1); kcmd = 0; wt(4);
    chk(xpin, 0, "cmd_clear");
    chk(run, 1, "cmd_run");
    alive = 1; wt(10 * T);
    chk(xp, 0, "pin_kicks");
    kpe = 0; wt((tms + 1) * T + 10);
    chk(xp, 1, "pin_unused");
    kpe = 1; wt(16);
    chk(xp, 0, "pin_restart");
    // Expiry routed to the system reset instead of the expiry pin
    rst_n = 0; alive = 0; e2r = 1; wsel = 0; wt(3); rst_n = 1;
    wt(8);
    chk(rst_o, 1, "tied_rel");
    d = 0;
    repeat ((tms + 2) * T) begin
      @(negedge clk);
      if (rst_o === 1'b0) d = 1;
    end
    chk(d[15:0], 1, "wd_reset");
    chk(xpin, 0, "tied_pin");
    // Tracking release, active-low input: after expiry reset waits for it
    rst_n = 0; trel = 1; tpol = 0; tpin = 1; wt(3); rst_n = 1;
    wt(8);
    chk(rst_o, 1, "trk_first");
    wt((tms + 2) * T);
    chk(rst_o, 0, "trk_hold");
    tpin = 0; wt(8);
    chk(rst_o, 1, "trk_release");
    end_of_test;
  end
endmodule
